//--- logic/cfg_pkg.sv
// Purpose: shared constants and carriers for the serial configuration controller
// Assumes: 50 MHz system clock, plain register port with one-cycle read latency
// Notes: the list below summarises the behaviour the controller keeps
`default_nettype none

package cfg_pkg;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_IO_ASSIGN = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CRC = 4'hc;

    // status word field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MASTER_BIT = 4;
    localparam int STAT_SLAVE_BIT = 5;
    localparam int STAT_CRCERR_BIT = 6;
    localparam int STAT_RATE_LSB = 8;
    localparam int STAT_CYC_LSB = 16;
    localparam int STAT_INIT_BIT = 20;
    localparam int STAT_DONE_BIT = 21;

    // start-up cycle numbers and default event cycles
    localparam logic [2:0] CYC_FIRST = 3'h1;
    localparam logic [2:0] CYC_LAST_EVT = 3'h6;
    localparam logic [2:0] CYC_FINAL = 3'h7;
    localparam logic [2:0] DEF_DONE_CYC = 3'h4;
    localparam logic [2:0] DEF_GTS_CYC = 3'h5;
    localparam logic [2:0] DEF_GSR_CYC = 3'h6;
    localparam logic [2:0] DEF_GWE_CYC = 3'h6;

    // mode pin patterns, as {mode_sel_1, mode_sel_0}
    localparam logic [1:0] MODE_SEL_MASTER = 2'h0;
    localparam logic [1:0] MODE_SEL_SLAVE = 2'h3;

    // clock timing
    localparam int SYS_CLK_KHZ = 50000;
    localparam int SYS_CLK_MHZ = 50;
    localparam int INIT_CFG_KHZ = 2500;
    localparam logic [7:0] INIT_HALF = 8'(SYS_CLK_KHZ / (2 * INIT_CFG_KHZ));
    localparam logic [7:0] HALF_MIN = 8'h02;
    localparam int RATE_W = 6;
    localparam logic [5:0] DEFAULT_RATE_MHZ = 6'h04;
    localparam logic [5:0] MAX_RATE_MHZ = 6'h3c;
    localparam int RATE_BYTES = 60;
    localparam int BYTE_BITS = 8;
    localparam int RATE_SWITCH_BITS = RATE_BYTES * BYTE_BITS;

    // crc
    localparam int CRC_W = 16;

    // controller states
    typedef enum logic [2:0] {
        ST_CLEAR,
        ST_RELEASE,
        ST_LOAD,
        ST_START,
        ST_USER,
        ST_ERROR,
        ST_NOMODE
    } state_t;

    // software control word, low bits of the control register
    typedef struct packed {
        logic active_drive;  // active_completion_drive
        logic wait_done;     // wait_for_completion_startup
        logic [2:0] gwe_cyc;
        logic [2:0] gsr_cyc;
        logic [2:0] gts_cyc;
        logic [2:0] done_cyc;
    } ctrl_t;
    localparam int CTRL_W = $bits(ctrl_t);
    localparam ctrl_t CTRL_RESET = '{1'b0, 1'b0, DEF_GWE_CYC, DEF_GSR_CYC,
                                     DEF_GTS_CYC, DEF_DONE_CYC};

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // global nets toward the fabric
    typedef struct packed {
        logic global_tristate;
        logic global_set_reset;
        logic global_write_en;
    } global_ctl_t;

endpackage

`default_nettype wire

//--- logic/serial_config_startup_controller.sv
// Purpose: memory clear, mode latch, serial load with crc, start-up sequencer
// Assumes: pins and the configuration clock are asynchronous to clk_sys_in
// Notes: master clock tops out at a quarter of the system clock
`default_nettype none

module serial_config_startup_controller #(
    parameter int LOAD_BITS = 4096,          // data bits ahead of the crc word
    parameter logic [15:0] CRC_POLY = 16'h8005,
    parameter logic [15:0] CRC_SEED = 16'h0000,
    parameter int RATE_POS = 32,             // first bit of the rate option field
    parameter int CLEAR_CYCLES = 256,        // memory clear time in system cycles
    parameter int IO_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire cfg_pkg::bus_req_t bus_in,
    output logic [cfg_pkg::DATA_W-1:0] rdata_out,
    input wire logic program_n_in,
    input wire logic init_n_in,
    output logic init_n_out,
    output logic init_n_oe_n_out,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_n_out,
    input wire logic mode_sel_0_in,
    input wire logic mode_sel_1_in,
    input wire logic mode_sel_2_in,
    input wire logic cfg_clock_in,
    output logic cfg_clock_out,
    output logic cfg_clock_oe_n_out,
    input wire logic din_in,
    output logic dout_out,
    output cfg_pkg::global_ctl_t global_out,
    output logic [IO_W-1:0] io_tristate_out,
    output logic [IO_W-1:0] io_pulldown_out
);
    import cfg_pkg::*;
    // bit counter limits, sized to the counter
    localparam logic [23:0] DATA_END = 24'(LOAD_BITS);
    localparam logic [23:0] LAST_BIT = 24'(LOAD_BITS + CRC_W - 1);
    localparam logic [23:0] RATE_LO = 24'(RATE_POS);
    localparam logic [23:0] RATE_HI = 24'(RATE_POS + RATE_W);
    localparam logic [23:0] SWITCH_BIT = 24'(RATE_SWITCH_BITS - 1);
    localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);
    // whole module state
    typedef struct packed {
        state_t st;
        ctrl_t ctrl;
        logic [IO_W-1:0] io_assign;  // software map of assigned ios
        logic [DATA_W-1:0] rdata;
        logic prog_s1, prog_s2;      // synchronisers, stage 1 read by stage 2 only
        logic init_s1, init_s2;
        logic done_s1, done_s2;
        logic cfg_s1, cfg_s2, cfg_s3;
        logic din_s1, din_s2;
        logic [2:0] mode_s1, mode_s2;
        logic [2:0] mode;            // latched mode pins, bit 0 is mode_sel_0
        logic [15:0] clr_cnt;
        logic [23:0] bit_cnt;
        logic [CRC_W-1:0] crc;       // running crc over data bits
        logic [CRC_W-1:0] rx_crc;    // crc word carried in the stream
        logic crc_err;
        logic [RATE_W-1:0] rate;     // clock_rate_option from the stream
        logic rate_sel;              // rate option now in force
        logic [7:0] div_cnt;
        logic cfg_out, cfg_oe_n;
        logic [2:0] cyc;             // start-up cycle c0..c7
        logic done_seen, evt_fired;
        logic init_oe_n, done_lvl, done_o, done_oe_n, dout;
        global_ctl_t glob;
        logic [IO_W-1:0] io_tri, io_pd;
    } core_t;
    core_t q;
    core_t d;
    logic tick_c;            // one-cycle pulse per configuration clock rise
    logic master_c;
    logic slave_c;
    logic run_clk_c;
    logic [7:0] half_c;
    logic [2:0] nxt_c;
    logic crc_ok_c;
    logic [DATA_W-1:0] status_c;
    // one serial crc step, msb first
    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
        logic fb;
        fb = b ^ c[CRC_W-1];
        return {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    endfunction

    // half period in system cycles for a rate in MHz, rounded up (slower is safe)
    function automatic logic [7:0] rate_half(input logic [RATE_W-1:0] mhz);
        int r;
        int h;
        r = int'(mhz);
        if (mhz < DEFAULT_RATE_MHZ) begin
            r = int'(DEFAULT_RATE_MHZ);
        end else if (mhz > MAX_RATE_MHZ) begin
            r = int'(MAX_RATE_MHZ);
        end
        h = (SYS_CLK_MHZ + 2 * r - 1) / (2 * r);
        return (8'(h) < HALF_MIN) ? HALF_MIN : 8'(h);
    endfunction

    // keep programmed event cycles inside c1..c6
    function automatic logic [2:0] cyc_clamp(input logic [2:0] v);
        if (v < CYC_FIRST) begin
            return CYC_FIRST;
        end
        if (v > CYC_LAST_EVT) begin
            return CYC_LAST_EVT;
        end
        return v;
    endfunction

    // next-state logic
    always_comb begin
        d = q;
        tick_c = 1'b0;
        nxt_c = q.cyc + 3'h1;
        crc_ok_c = 1'b0;
        status_c = '0;
        // synchronisers
        d.prog_s1 = program_n_in;
        d.prog_s2 = q.prog_s1;
        d.init_s1 = init_n_in;
        d.init_s2 = q.init_s1;
        d.done_s1 = done_in;
        d.done_s2 = q.done_s1;
        d.cfg_s1 = cfg_clock_in;
        d.cfg_s2 = q.cfg_s1;
        d.cfg_s3 = q.cfg_s2;
        d.din_s1 = din_in;
        d.din_s2 = q.din_s1;
        d.mode_s1 = {mode_sel_2_in, mode_sel_1_in, mode_sel_0_in};
        d.mode_s2 = q.mode_s1;
        master_c = (q.mode[1:0] == MODE_SEL_MASTER);
        slave_c = (q.mode[1:0] == MODE_SEL_SLAVE);
        run_clk_c = (q.st == ST_LOAD) || (q.st == ST_START) || (q.st == ST_USER);
        // slow fixed rate until the first RATE_BYTES bytes have been clocked in
        // rounding the half period up keeps us inside the slow side of the tolerance
        half_c = q.rate_sel ? rate_half(q.rate) : INIT_HALF;
        // configuration clock: generated in master mode, edge-found in slave mode
        if (master_c && run_clk_c) begin
            d.cfg_oe_n = 1'b0;
            if (q.div_cnt >= half_c - 8'h01) begin
                d.div_cnt = '0;
                d.cfg_out = ~q.cfg_out;
                tick_c = ~q.cfg_out;
            end else begin
                d.div_cnt = q.div_cnt + 8'h01;
            end
        end else begin
            d.cfg_oe_n = 1'b1;
            d.cfg_out = 1'b0;
            d.div_cnt = '0;
            tick_c = slave_c && run_clk_c && q.cfg_s2 && !q.cfg_s3;
        end

        // register writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                REG_CTRL: begin
                    d.ctrl = ctrl_t'(bus_in.wdata[CTRL_W-1:0]);
                end
                REG_IO_ASSIGN: begin
                    d.io_assign = bus_in.wdata[IO_W-1:0];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // status word
        status_c[STAT_STATE_LSB +: 3] = q.st;
        status_c[STAT_MASTER_BIT] = master_c;
        status_c[STAT_SLAVE_BIT] = slave_c;
        status_c[STAT_CRCERR_BIT] = q.crc_err;
        status_c[STAT_RATE_LSB +: RATE_W] = q.rate;
        status_c[STAT_CYC_LSB +: 3] = q.cyc;
        status_c[STAT_INIT_BIT] = q.init_s2;
        status_c[STAT_DONE_BIT] = q.done_s2;
        // read data stands only in the cycle after the strobe
        d.rdata = '0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                REG_CTRL: d.rdata = DATA_W'(q.ctrl);
                REG_IO_ASSIGN: d.rdata = DATA_W'(q.io_assign);
                REG_STATUS: d.rdata = status_c;
                REG_CRC: d.rdata = {q.rx_crc, q.crc};
                default: d.rdata = '0;
            endcase
        end

        case (q.st)
            ST_CLEAR: begin
                // memory clear: init held low, fabric frozen
                d.init_oe_n = 1'b0;
                d.done_lvl = 1'b0;
                d.glob = '{1'b1, 1'b1, 1'b0};
                d.cyc = '0;
                d.bit_cnt = '0;
                d.crc = CRC_SEED;
                d.rx_crc = '0;
                d.rate = '0;
                d.rate_sel = 1'b0;
                d.done_seen = 1'b0;
                d.evt_fired = 1'b0;
                d.crc_err = 1'b0;
                if (!q.prog_s2) begin
                    d.clr_cnt = '0;
                end else if (q.clr_cnt == CLEAR_LAST) begin
                    d.st = ST_RELEASE;
                end else begin
                    d.clr_cnt = q.clr_cnt + 16'h0001;
                end
            end
            ST_RELEASE: begin
                // line released; an outside open-drain low keeps us here
                d.init_oe_n = 1'b1;
                if (q.init_s2 && q.init_oe_n) begin
                    d.mode = q.mode_s2;
                    if ((q.mode_s2[1:0] == MODE_SEL_MASTER) ||
                        (q.mode_s2[1:0] == MODE_SEL_SLAVE)) begin
                        d.st = ST_LOAD;
                    end else begin
                        d.st = ST_NOMODE;
                    end
                end
            end
            ST_LOAD: begin
                if (tick_c) begin
                    // bits arrive msb first; the shift keeps that order
                    d.bit_cnt = q.bit_cnt + 24'h000001;
                    if (q.bit_cnt < DATA_END) begin
                        d.crc = crc_step(q.crc, q.din_s2);
                        if ((q.bit_cnt >= RATE_LO) && (q.bit_cnt < RATE_HI)) begin
                            d.rate = {q.rate[RATE_W-2:0], q.din_s2};
                        end
                    end else begin
                        d.rx_crc = {q.rx_crc[CRC_W-2:0], q.din_s2};
                    end
                    if (q.bit_cnt == SWITCH_BIT) begin
                        d.rate_sel = 1'b1;
                    end
                    if (q.bit_cnt == LAST_BIT) begin
                        crc_ok_c = (q.crc == {q.rx_crc[CRC_W-2:0], q.din_s2});
                        if (crc_ok_c) begin
                            d.st = ST_START;
                            d.cyc = '0;
                        end else begin
                            d.st = ST_ERROR;
                            d.crc_err = 1'b1;
                            d.init_oe_n = 1'b0;
                        end
                    end
                end
            end
            ST_START: begin
                if (tick_c) begin
                    if (nxt_c >= cyc_clamp(q.ctrl.done_cyc)) begin
                        d.done_lvl = 1'b1;
                    end
                    if (!q.ctrl.wait_done) begin
                        // each event on its own programmed cycle
                        if (nxt_c >= cyc_clamp(q.ctrl.gts_cyc)) begin
                            d.glob.global_tristate = 1'b0;
                        end
                        if (nxt_c >= cyc_clamp(q.ctrl.gsr_cyc)) begin
                            d.glob.global_set_reset = 1'b0;
                        end
                        if (nxt_c >= cyc_clamp(q.ctrl.gwe_cyc)) begin
                            d.glob.global_write_en = 1'b1;
                        end
                        d.evt_fired = 1'b1;
                    end else if (q.done_seen) begin
                        // one clock after the pin was seen high
                        d.glob = '{1'b0, 1'b0, 1'b1};
                        d.evt_fired = 1'b1;
                    end else if (q.done_s2) begin
                        d.done_seen = 1'b1;
                    end
                    // hold at c6 until the completion-gated events are out
                    if (q.cyc == CYC_FINAL) begin
                        d.st = ST_USER;
                    end else if (!(q.ctrl.wait_done && !q.evt_fired &&
                                   q.cyc == CYC_LAST_EVT)) begin
                        d.cyc = nxt_c;
                    end
                end
            end
            ST_USER: begin
                if (tick_c) begin
                    d.dout = q.din_s2;
                end
            end
            ST_ERROR: begin
                d.init_oe_n = 1'b0;
            end
            default: begin
                // unsupported mode: wait for a reconfigure request
            end
        endcase

        // reconfigure request overrides every phase
        if (!q.prog_s2 && (q.st != ST_CLEAR)) begin
            d.st = ST_CLEAR;
            d.done_lvl = 1'b0;
            d.clr_cnt = '0;
        end

        // completion pin: open-drain unless active drive is chosen
        d.done_o = d.done_lvl & d.ctrl.active_drive;
        d.done_oe_n = d.done_lvl & ~d.ctrl.active_drive;
        // only assigned ios leave tristate; the rest keep their pull-downs
        d.io_tri = d.glob.global_tristate ? '1 : ~d.io_assign;
        d.io_pd = ~d.io_assign;
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
            q.st <= ST_CLEAR;
            q.ctrl <= CTRL_RESET;
            q.crc <= CRC_SEED;
            q.init_oe_n <= 1'b0;
            q.done_oe_n <= 1'b0;
            q.cfg_oe_n <= 1'b1;
            q.glob <= '{1'b1, 1'b1, 1'b0};
            q.io_tri <= '1;
        end else begin
            q <= d;
        end
    end

    // pins straight from flops; init only ever pulls low
    assign rdata_out = q.rdata;
    assign init_n_out = 1'b0 & q.init_oe_n;
    assign init_n_oe_n_out = q.init_oe_n;
    assign done_out = q.done_o;
    assign done_oe_n_out = q.done_oe_n;
    assign cfg_clock_out = q.cfg_out;
    assign cfg_clock_oe_n_out = q.cfg_oe_n;
    assign dout_out = q.dout;
    assign global_out = q.glob;
    assign io_tristate_out = q.io_tri;
    assign io_pulldown_out = q.io_pd;

    // checks on the controller itself
    init_clear_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_CLEAR) |=> !init_n_oe_n_out)
        else $error("init not driven low while clearing");
    clear_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_RELEASE) && !q.init_s2) |=> (q.st inside {ST_RELEASE, ST_CLEAR}))
        else $error("left clearing while init held low");
    mode_latch_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_RELEASE) && (d.st == ST_LOAD)) |=>
            ((q.mode == $past(q.mode_s2)) && init_n_oe_n_out))
        else $error("mode pins not latched on init release");
    crc_abort_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_ERROR) && q.prog_s2) |=> ((q.st == ST_ERROR) && !init_n_oe_n_out))
        else $error("crc error state left or init released");
    start_crc_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(q.st == ST_START) |-> ($past(crc_ok_c) && (q.cyc == 3'h0)))
        else $error("start-up entered without crc match");
    seq_end_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_START) && (q.cyc == CYC_FINAL) && tick_c && q.prog_s2) |=>
            ((q.st == ST_USER) && !global_out.global_set_reset))
        else $error("start-up did not end after c7");
    done_ack_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_USER) && !q.prog_s2) |=> (!done_out && !done_oe_n_out))
        else $error("completion pin not pulled low on reconfigure");
    slave_clk_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_LOAD) && slave_c) |-> cfg_clock_oe_n_out)
        else $error("clock driven in slave mode");
    slow_rate_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_LOAD) && master_c && (q.bit_cnt < SWITCH_BIT)) |-> (half_c == INIT_HALF))
        else $error("master clock not at start rate");
    chain_fwd_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_USER) && tick_c && q.prog_s2) |=> (dout_out == $past(q.din_s2)))
        else $error("chain output not updated on clock rise");
    wait_evt_a: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ((q.st == ST_START) && q.ctrl.wait_done && !q.done_seen) |-> global_out.global_tristate)
        else $error("tristate released before completion seen");

endmodule // serial_config_startup_controller

`default_nettype wire

//--- bench/cfg_source.sv
// Purpose: serial slave source, clocks a frame msb first
// Assumes: the link clock stands still outside frames
// Notes: no write strobe pin exists, so it is never toggled
`default_nettype none
module cfg_source (
    input wire logic init_in,
    input wire logic go_in,
    input wire logic [79:0] frame_in,
    input wire logic [6:0] nbits_in,
    output logic clk_out,
    output logic din_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        clk_out = 1'b0;
        din_out = 1'b0;
        busy_out = 1'b0;
    end
    // one frame per rising go; strobe stays quiet
    always @(posedge go_in) begin
        busy_out = 1'b1;
        for (int k = 0; k < 4000 && init_in !== 1'b1; k++) #20;
        #5; // start off the system clock edges to avoid sampling races
        for (int i = nbits_in - 1; i >= 0; i--) begin
            din_out = frame_in[i];
            #80 clk_out = 1'b1;
            #80 clk_out = 1'b0;
        end
        // released data line shows the inverse, not a held value
        din_out = ~din_out;
        busy_out = 1'b0;
    end
endmodule // cfg_source
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for the configuration controller
// Assumes: init and done lines pulled up, slave source model
// Notes: short load and clear counts keep the run brief
`default_nettype none
module testbench;
    import cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, reset_n_in, prog_n, hold, m0, m1, go, dout, s_clk, s_din, busy;
    logic init_oe_n, init_o, done_o, done_oe_n, ck_o, ck_oe_n, init_w, done_w, ck_w;
    bus_req_t bus_q;
    logic [31:0] rdata, q;
    global_ctl_t glob;
    logic [7:0] io_ts, io_pd;
    logic [79:0] frame;
    logic [6:0] nbits;
    int err_total, total_checks, n;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    row_t rows [7] = '{'{1'b0, REG_CTRL, 32'h0, 32'h0000_0dac},
        '{1'b0, REG_IO_ASSIGN, 32'h0, 32'h0}, '{1'b0, 4'h2, 32'h0, 32'h0},
        '{1'b1, REG_CTRL, 32'h0000_0eca, 32'h0}, '{1'b0, REG_CTRL, 32'h0, 32'h0000_0eca},
        '{1'b1, REG_IO_ASSIGN, 32'h0000_000f, 32'h0}, '{1'b0, REG_IO_ASSIGN, 32'h0, 32'h0000_000f}};
    // open-drain init and done with pull-ups; bench holds init only by pulling
    assign init_w = ~hold & init_oe_n;
    assign done_w = done_oe_n ? 1'b1 : done_o;
    assign ck_w = ck_oe_n ? s_clk : ck_o;
    serial_config_startup_controller #(.LOAD_BITS(64), .CLEAR_CYCLES(8), .IO_W(8)) u_serial_config_startup_controller (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .bus_in(bus_q), .rdata_out(rdata),
        .program_n_in(prog_n), .init_n_in(init_w), .init_n_out(init_o),
        .init_n_oe_n_out(init_oe_n), .done_in(done_w), .done_out(done_o),
        .done_oe_n_out(done_oe_n), .mode_sel_0_in(m0), .mode_sel_1_in(m1), .mode_sel_2_in(1'b1),
        .cfg_clock_in(ck_w), .cfg_clock_out(ck_o), .cfg_clock_oe_n_out(ck_oe_n), .din_in(s_din),
        .dout_out(dout), .global_out(glob), .io_tristate_out(io_ts), .io_pulldown_out(io_pd));
    cfg_source u_cfg_source (.init_in(init_w), .go_in(go), .frame_in(frame), .nbits_in(nbits),
        .clk_out(s_clk), .din_out(s_din), .busy_out(busy));
    // 50 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one strobe cycle; read data taken in the following cycle only
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus_q <= '{a, d, w, ~w};
        @(posedge clk_sys_in);
        bus_q.wr <= 1'b0;
        bus_q.rd <= 1'b0;
        #1 q = rdata;
    endtask
    // one frame from the source model; bounded wait until it has clocked out
    task automatic send(input logic [79:0] f, input logic [6:0] nb);
        go <= 1'b0;
        frame <= f;
        nbits <= nb;
        @(posedge clk_sys_in);
        go <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk_sys_in);
        check(busy, 1'b0);
        if (busy !== 1'b0) tally_and_finish();
    endtask
    // poll state with a bounded count
    task automatic wait_state(input logic [2:0] s);
        for (int k = 0; k < 3000; k++) begin
            bus(1'b0, REG_STATUS, 32'h0);
            if (q[2:0] === s) return;
        end
        check(q[2:0], s);
        tally_and_finish();
    endtask
    function automatic logic [15:0] crc_of(input logic [63:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 63; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0);
        return c;
    endfunction
    // main sequence
    initial begin
        err_total = 0; total_checks = 0; reset_n_in = 1'b0; bus_q = '0; prog_n = 1'b1;
        hold = 1'b1; m0 = 1'b1; m1 = 1'b1; go = 1'b0; frame = '0; nbits = 7'h50;
        repeat (2) @(posedge clk_sys_in);
        check({init_o, init_oe_n}, 2'h0);
        check({done_o, glob}, 4'h6);
        reset_n_in <= 1'b1;
        repeat (30) @(posedge clk_sys_in);
        bus(1'b0, REG_STATUS, 32'h0);
        check({q[2:0], init_w}, 4'h2);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(q, rows[i].e);
        end
        hold <= 1'b0;
        send({64'h0123_4567_89ab_cdef, crc_of(64'h0123_4567_89ab_cdef)}, 7'h50);
        // start-up needs eight more link clocks after the crc
        send(80'h0, 7'h08);
        wait_state(3'h4);
        check({q[5], glob, done_w}, 5'h13);
        check({io_ts, io_pd}, 16'hf0f0);
        send(80'hff, 7'h08);
        repeat (4) @(posedge clk_sys_in);
        check(dout, 1'b1);
        prog_n <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check(done_w, 1'b0);
        prog_n <= 1'b1;
        // second load in wait-for-completion mode with active completion drive
        bus(1'b1, REG_CTRL, 32'h0000_3eca);
        send({64'h0123_4567_89ab_cdef, crc_of(64'h0123_4567_89ab_cdef)}, 7'h50);
        send(80'h0, 7'h08);
        wait_state(3'h4);
        check({glob, done_w, done_oe_n}, 5'h06);
        prog_n <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        prog_n <= 1'b1;
        send({64'h0123_4567_89ab_cdef, ~crc_of(64'h0123_4567_89ab_cdef)}, 7'h50);
        wait_state(3'h5);
        check({q[6], init_oe_n}, 2'h2);
        prog_n <= 1'b0; m0 <= 1'b0; m1 <= 1'b0;
        wait_state(3'h0);
        prog_n <= 1'b1;
        wait_state(3'h2);
        check(ck_oe_n, 1'b0);
        for (n = 0; n < 200 && ck_o !== 1'b1; n++) begin @(posedge clk_sys_in); #1; end
        for (n = 0; n < 200 && ck_o === 1'b1; n++) begin @(posedge clk_sys_in); #1; end
        check(32'(n), 32'd10);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
